// ---- verilog/sdrpi_map.vh ----
// Constants for the SDR SDRAM pin interface: command codes, address fields, reset values, timing counts.
// Functional notes
// - The memory data bus runs either thirty-two or sixteen bits wide toward SDR or mobile SDR SDRAM.
// - Reads and writes enter over separate split-transaction channels with their own holding slots, so both may be outstanding together.
// - A pending refresh is served first, with one auto-refresh cycle, before a newly received access starts.
// - The active-low chip select stays asserted at all times, idle periods included.
// - One byte-mask output per data byte lane enables or disables that byte during a data transfer.
// - The clock-enable output is taken low to issue self refresh and hold the memory in self refresh.
// - Commands are sent on the active-low row, column and write strobes.
// - A two-bit bank select taken from the request address supplies the memory bank.
// - Row and column addresses taken from the request address go out on the shared address bus at activate and read or write.
// - Self refresh and prioritised refresh are supported, with refresh rate, CAS latency and timings programmable.
// - Strobe levels per command: precharge LHL, activate LHH, read HLH, write HLL, burst stop HHL, mode load LLL, refresh LLH, idle HHH, self refresh LLH with clock enable low.
// - Every cycle that carries no other command carries the idle command.
// - Address bit ten is low with read and write so auto-precharge is never requested.
// - Precharge drives address bit ten high to close all banks, low to close only the selected bank.
`ifndef SDRPI_MAP_VH
`define SDRPI_MAP_VH

// Strobe code {row, column, write}
`define SDRPI_CMD_PRECHARGE     3'h2
`define SDRPI_CMD_ACTIVATE      3'h3
`define SDRPI_CMD_READ          3'h5
`define SDRPI_CMD_WRITE         3'h4
`define SDRPI_CMD_BURST_STOP    3'h6
`define SDRPI_CMD_MODE_LOAD     3'h0
`define SDRPI_CMD_AUTO_REFRESH  3'h1
`define SDRPI_CMD_SELF_REFRESH  3'h1
`define SDRPI_CMD_IDLE          3'h7

`define SDRPI_MA_W              13
`define SDRPI_AP_BIT            10
`define SDRPI_MODE_CL_LSB       4

`define SDRPI_RST_CMD           3'h7
`define SDRPI_RST_CKE           1'b1
`define SDRPI_RST_MA            13'h0000
`define SDRPI_RST_BA            2'h0
`define SDRPI_RST_MASK          4'hf

`define SDRPI_INIT_REFRESHES    4'h2
`define SDRPI_TMRD_CYC          4'h2
`define SDRPI_TWR_CYC           4'h2
`define SDRPI_RD_PIPE           4'h2
`define SDRPI_INIT_WAIT_NS      100000
`define SDRPI_CLK_PERIOD_PS     5000
`define SDRPI_INIT_WAIT_CYC     ((`SDRPI_INIT_WAIT_NS * 1000 + `SDRPI_CLK_PERIOD_PS - 1) / `SDRPI_CLK_PERIOD_PS)

`endif

// ---- verilog/sdrpi_core.v ----
// SDR SDRAM pin interface: request slots, init, refresh, self refresh and command sequencing.
`timescale 1ns/1ps
`include "sdrpi_map.vh"

module sdrpi_core #(
   parameter COL_W         = 9,
   parameter ID_W          = 4,
   parameter INIT_WAIT_CYC = `SDRPI_INIT_WAIT_CYC
) (
   input  wire                          clk_sys,
   input  wire                          resetn,
   input  wire                          cfg_bus16,
   input  wire [2:0]                    cfg_cas_lat,
   input  wire [3:0]                    cfg_trcd,
   input  wire [3:0]                    cfg_trp,
   input  wire [3:0]                    cfg_trfc,
   input  wire [12:0]                   cfg_refresh_period,
   input  wire                          self_refresh_req,
   output reg                           self_refresh_active,
   output reg                           init_done,
   input  wire                          wr_valid,
   output wire                          wr_ready,
   input  wire [COL_W+14:0]             wr_addr,
   input  wire [31:0]                   wr_data,
   input  wire [3:0]                    wr_byte_en,
   input  wire [ID_W-1:0]               wr_id,
   output reg                           wr_done,
   output reg  [ID_W-1:0]               wr_done_id,
   input  wire                          rd_valid,
   output wire                          rd_ready,
   input  wire [COL_W+14:0]             rd_addr,
   input  wire [ID_W-1:0]               rd_id,
   output reg                           rd_data_valid,
   output reg  [31:0]                   rd_data,
   output reg  [ID_W-1:0]               rd_data_id,
   output wire                          mem_clock_out,
   output reg                           mem_clock_enable,
   output reg                           chip_select_n,
   output reg                           row_strobe_n,
   output reg                           column_strobe_n,
   output reg                           write_strobe_n,
   output reg  [1:0]                    mem_bank_select,
   output reg  [`SDRPI_MA_W-1:0]        mem_addr_bus,
   output reg  [3:0]                    byte_lane_mask,
   output reg  [31:0]                   mem_data_out,
   output reg                           mem_data_oe,
   input  wire [31:0]                   mem_data_in
);

   localparam ADDR_W = COL_W + 15;

   localparam ST_INIT_WAIT = 4'h0;
   localparam ST_INIT_PRE  = 4'h1;
   localparam ST_INIT_REF  = 4'h2;
   localparam ST_INIT_MODE = 4'h3;
   localparam ST_IDLE      = 4'h4;
   localparam ST_REFRESH   = 4'h5;
   localparam ST_RW        = 4'h6;
   localparam ST_RD_WAIT   = 4'h7;
   localparam ST_PRE       = 4'h8;
   localparam ST_SR_HOLD   = 4'h9;
   localparam ST_WAIT      = 4'ha;

   // ************************************************************
   // Helpers
   // ************************************************************
   // A programmed zero still gives one cycle of spacing.
   function [14:0] sdrpi_wait_load;
      input [3:0] v;
      begin
         sdrpi_wait_load = (v == 4'h0) ? 15'h0000 : {11'h000, v - 4'h1};
      end
   endfunction

   function [`SDRPI_MA_W-1:0] sdrpi_col;
      input [COL_W-1:0] c;
      integer i;
      begin
         sdrpi_col = `SDRPI_RST_MA;
         for (i = 0; i < COL_W; i = i + 1) begin
            sdrpi_col[i] = c[i];
         end
         sdrpi_col[`SDRPI_AP_BIT] = 1'b0;
      end
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   reg  [3:0]           state;
   reg  [3:0]           ret_state;
   reg  [14:0]          cnt;
   reg  [3:0]           refs_left;
   reg  [12:0]          ref_timer;
   reg                  ref_pending;
   reg                  cur_write;
   reg  [ADDR_W-1:0]    cur_addr;
   reg                  last_write;

   reg                  wr_full;
   reg  [ADDR_W-1:0]    wr_slot_addr;
   reg  [31:0]          wr_slot_data;
   reg  [3:0]           wr_slot_be;
   reg  [ID_W-1:0]      wr_slot_id;
   reg                  rd_full;
   reg  [ADDR_W-1:0]    rd_slot_addr;
   reg  [ID_W-1:0]      rd_slot_id;

   reg  [31:0]          din_meta;
   reg  [31:0]          din_sync;

   reg  [3:0]           next_state;
   reg  [3:0]           next_ret_state;
   reg  [14:0]          next_cnt;
   reg  [3:0]           next_refs_left;
   reg  [2:0]           next_cmd;
   reg                  next_cke;
   reg  [1:0]           next_ba;
   reg  [`SDRPI_MA_W-1:0] next_ma;
   reg  [3:0]           next_mask;
   reg  [31:0]          next_dout;
   reg                  next_oe;
   reg                  next_cur_write;
   reg  [ADDR_W-1:0]    next_cur_addr;
   reg                  ref_clear;
   reg                  wr_take;
   reg                  rd_finish;

   wire [1:0]           cur_bank = cur_addr[COL_W+1:COL_W];
   wire [COL_W-1:0]     cur_col  = cur_addr[COL_W-1:0];
   wire                 pick_write = wr_full & (~rd_full | ~last_write);
   wire                 ref_fire = (ref_timer == 13'h0000) & init_done & ~self_refresh_active;

   // Slots are the split-transaction holding stage; one read and one write may wait together.
   assign wr_ready = ~wr_full;
   assign rd_ready = ~rd_full;
   assign mem_clock_out = clk_sys;

   // ************************************************************
   // Command sequencing
   // ************************************************************
   always @* begin
      next_state     = state;
      next_ret_state = ret_state;
      next_cnt       = cnt;
      next_refs_left = refs_left;
      next_cmd       = `SDRPI_CMD_IDLE;
      next_cke       = 1'b1;
      next_ba        = mem_bank_select;
      next_ma        = mem_addr_bus;
      next_mask      = `SDRPI_RST_MASK;
      next_dout      = mem_data_out;
      next_oe        = 1'b0;
      next_cur_write = cur_write;
      next_cur_addr  = cur_addr;
      ref_clear      = 1'b0;
      wr_take        = 1'b0;
      rd_finish      = 1'b0;
      case (state)
         ST_INIT_WAIT: begin
            if (cnt == 15'h0000) begin
               next_state = ST_INIT_PRE;
            end else begin
               next_cnt = cnt - 15'h0001;
            end
         end
         ST_INIT_PRE: begin
            next_cmd       = `SDRPI_CMD_PRECHARGE;
            next_ma        = `SDRPI_RST_MA;
            next_ma[`SDRPI_AP_BIT] = 1'b1;
            next_refs_left = `SDRPI_INIT_REFRESHES;
            next_cnt       = sdrpi_wait_load(cfg_trp);
            next_state     = ST_WAIT;
            next_ret_state = ST_INIT_REF;
         end
         ST_INIT_REF: begin
            next_cmd       = `SDRPI_CMD_AUTO_REFRESH;
            next_refs_left = refs_left - 4'h1;
            next_cnt       = sdrpi_wait_load(cfg_trfc);
            next_state     = ST_WAIT;
            next_ret_state = (refs_left == 4'h1) ? ST_INIT_MODE : ST_INIT_REF;
         end
         ST_INIT_MODE: begin
            // Burst length one, sequential, CAS latency from configuration
            next_cmd       = `SDRPI_CMD_MODE_LOAD;
            next_ma        = `SDRPI_RST_MA;
            next_ma[`SDRPI_MODE_CL_LSB+2:`SDRPI_MODE_CL_LSB] = cfg_cas_lat;
            next_ba        = `SDRPI_RST_BA;
            next_cnt       = sdrpi_wait_load(`SDRPI_TMRD_CYC);
            next_state     = ST_WAIT;
            next_ret_state = ST_IDLE;
         end
         ST_IDLE: begin
            // Refresh outranks both self refresh entry and any waiting access.
            if (ref_pending) begin
               next_state = ST_REFRESH;
            end else if (self_refresh_req) begin
               next_cmd   = `SDRPI_CMD_SELF_REFRESH;
               next_cke   = 1'b0;
               next_state = ST_SR_HOLD;
            end else if (wr_full | rd_full) begin
               next_cur_write = pick_write;
               next_cur_addr  = pick_write ? wr_slot_addr : rd_slot_addr;
               next_cmd       = `SDRPI_CMD_ACTIVATE;
               next_ba        = next_cur_addr[COL_W+1:COL_W];
               next_ma        = next_cur_addr[ADDR_W-1:COL_W+2];
               next_cnt       = sdrpi_wait_load(cfg_trcd);
               next_state     = ST_WAIT;
               next_ret_state = ST_RW;
            end
         end
         ST_REFRESH: begin
            next_cmd       = `SDRPI_CMD_AUTO_REFRESH;
            ref_clear      = 1'b1;
            next_cnt       = sdrpi_wait_load(cfg_trfc);
            next_state     = ST_WAIT;
            next_ret_state = ST_IDLE;
         end
         ST_RW: begin
            next_ba = cur_bank;
            next_ma = sdrpi_col(cur_col);
            if (cur_write) begin
               next_cmd  = `SDRPI_CMD_WRITE;
               next_dout = wr_slot_data;
               next_oe   = 1'b1;
               // Mask high disables a lane; the upper lanes stay off on a narrow bus.
               next_mask = ~wr_slot_be | (cfg_bus16 ? 4'hc : 4'h0);
               wr_take   = 1'b1;
               next_cnt       = sdrpi_wait_load(`SDRPI_TWR_CYC);
               next_state     = ST_WAIT;
               next_ret_state = ST_PRE;
            end else begin
               next_cmd   = `SDRPI_CMD_READ;
               next_mask  = cfg_bus16 ? 4'hc : 4'h0;
               next_cnt   = {11'h000, {1'b0, cfg_cas_lat} + `SDRPI_RD_PIPE};
               next_state = ST_RD_WAIT;
            end
         end
         ST_RD_WAIT: begin
            if (cnt == 15'h0000) begin
               rd_finish  = 1'b1;
               next_state = ST_PRE;
            end else begin
               next_cnt = cnt - 15'h0001;
            end
         end
         ST_PRE: begin
            // Single-bank close keeps the other banks' state untouched.
            next_cmd       = `SDRPI_CMD_PRECHARGE;
            next_ba        = cur_bank;
            next_ma        = `SDRPI_RST_MA;
            next_cnt       = sdrpi_wait_load(cfg_trp);
            next_state     = ST_WAIT;
            next_ret_state = ST_IDLE;
         end
         ST_SR_HOLD: begin
            next_cke = ~self_refresh_req;
            if (~self_refresh_req) begin
               next_cnt       = sdrpi_wait_load(cfg_trfc);
               next_state     = ST_WAIT;
               next_ret_state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (cnt == 15'h0000) begin
               next_state = ret_state;
            end else begin
               next_cnt = cnt - 15'h0001;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always @(posedge clk_sys) begin
      if (!resetn) begin
         state               <= ST_INIT_WAIT;
         ret_state           <= ST_IDLE;
         cnt                 <= INIT_WAIT_CYC[14:0];
         refs_left           <= 4'h0;
         ref_timer           <= 13'h0000;
         ref_pending         <= 1'b0;
         cur_write           <= 1'b0;
         cur_addr            <= {ADDR_W{1'b0}};
         last_write          <= 1'b0;
         wr_full             <= 1'b0;
         wr_slot_addr        <= {ADDR_W{1'b0}};
         wr_slot_data        <= 32'h00000000;
         wr_slot_be          <= 4'h0;
         wr_slot_id          <= {ID_W{1'b0}};
         rd_full             <= 1'b0;
         rd_slot_addr        <= {ADDR_W{1'b0}};
         rd_slot_id          <= {ID_W{1'b0}};
         din_meta            <= 32'h00000000;
         din_sync            <= 32'h00000000;
         init_done           <= 1'b0;
         self_refresh_active <= 1'b0;
         wr_done             <= 1'b0;
         wr_done_id          <= {ID_W{1'b0}};
         rd_data_valid       <= 1'b0;
         rd_data             <= 32'h00000000;
         rd_data_id          <= {ID_W{1'b0}};
         mem_clock_enable    <= `SDRPI_RST_CKE;
         chip_select_n       <= 1'b0;
         {row_strobe_n, column_strobe_n, write_strobe_n} <= `SDRPI_RST_CMD;
         mem_bank_select     <= `SDRPI_RST_BA;
         mem_addr_bus        <= `SDRPI_RST_MA;
         byte_lane_mask      <= `SDRPI_RST_MASK;
         mem_data_out        <= 32'h00000000;
         mem_data_oe         <= 1'b0;
      end else begin
         state     <= next_state;
         ret_state <= next_ret_state;
         cnt       <= next_cnt;
         refs_left <= next_refs_left;
         cur_write <= next_cur_write;
         cur_addr  <= next_cur_addr;
         if (state == ST_IDLE && next_state == ST_WAIT) begin
            last_write <= next_cur_write;
         end
         // Refresh interval timer; a new request wins over a same-cycle clear.
         if (ref_fire) begin
            ref_timer <= cfg_refresh_period;
         end else if (init_done && !self_refresh_active) begin
            ref_timer <= ref_timer - 13'h0001;
         end else begin
            ref_timer <= cfg_refresh_period;
         end
         ref_pending <= ref_fire | (ref_pending & ~ref_clear);
         if (state == ST_INIT_MODE) begin
            init_done <= 1'b1;
         end
         self_refresh_active <= (next_state == ST_SR_HOLD);
         if (wr_valid && !wr_full) begin
            wr_full      <= 1'b1;
            wr_slot_addr <= wr_addr;
            wr_slot_data <= wr_data;
            wr_slot_be   <= wr_byte_en;
            wr_slot_id   <= wr_id;
         end else if (wr_take) begin
            wr_full <= 1'b0;
         end
         if (rd_valid && !rd_full) begin
            rd_full      <= 1'b1;
            rd_slot_addr <= rd_addr;
            rd_slot_id   <= rd_id;
         end else if (rd_finish) begin
            rd_full <= 1'b0;
         end
         wr_done       <= wr_take;
         wr_done_id    <= wr_take ? wr_slot_id : wr_done_id;
         // Read data pins pass two flops before capture.
         din_meta      <= mem_data_in;
         din_sync      <= din_meta;
         rd_data_valid <= rd_finish;
         if (rd_finish) begin
            rd_data    <= cfg_bus16 ? {16'h0000, din_sync[15:0]} : din_sync;
            rd_data_id <= rd_slot_id;
         end
         mem_clock_enable <= next_cke;
         chip_select_n    <= 1'b0;
         {row_strobe_n, column_strobe_n, write_strobe_n} <= next_cmd;
         mem_bank_select  <= next_ba;
         mem_addr_bus     <= next_ma;
         byte_lane_mask   <= next_mask;
         mem_data_out     <= next_dout;
         mem_data_oe      <= next_oe;
      end
   end

endmodule // sdrpi_core

// ---- verif/sdrpi_core_sva.sv ----
// Port checker for the SDR SDRAM pin interface
`timescale 1ns/1ps
`include "sdrpi_map.vh"
module sdrpi_core_sva (
   input logic        clk_sys,
   input logic        resetn,
   input logic [2:0]  cfg_cas_lat,
   input logic        init_done,
   input logic        wr_done,
   input logic        rd_data_valid,
   input logic        mem_clock_out,
   input logic        mem_clock_enable,
   input logic        chip_select_n,
   input logic        row_strobe_n,
   input logic        column_strobe_n,
   input logic        write_strobe_n,
   input logic [12:0] mem_addr_bus,
   input logic        mem_data_oe
);
   wire [2:0] cmd    = {row_strobe_n, column_strobe_n, write_strobe_n};
   wire       is_wr  = mem_clock_enable && cmd == `SDRPI_CMD_WRITE;
   wire       is_rd  = mem_clock_enable && cmd == `SDRPI_CMD_READ;
   wire       is_pre = mem_clock_enable && cmd == `SDRPI_CMD_PRECHARGE;
   wire       is_act = mem_clock_enable && cmd == `SDRPI_CMD_ACTIVATE;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   // ************************
   // Multi-step sequences
   // ************************
   sequence s_rd_return;
      ##1 !rd_data_valid [*4] ##1 rd_data_valid;
   endsequence
   sequence s_bank_close;
      ##3 is_pre && !mem_addr_bus[`SDRPI_AP_BIT];
   endsequence
   chk_cs_held: assert property (chip_select_n == 1'b0) else $error("chip select released");
   chk_rw_no_ap: assert property ((is_rd || is_wr) |-> !mem_addr_bus[`SDRPI_AP_BIT])
      else $error("auto precharge on access");
   chk_init_pre_all: assert property ((is_pre && !init_done) |-> mem_addr_bus[`SDRPI_AP_BIT])
      else $error("init precharge not all banks");
   chk_wr_bank_close: assert property (is_wr |-> s_bank_close) else $error("no bank precharge");
   chk_wr_done_cmd: assert property (wr_done == is_wr) else $error("write done off command");
   chk_oe_on_write: assert property (mem_data_oe == is_wr) else $error("data drive off write");
   chk_rd_latency: assert property ((is_rd && cfg_cas_lat == 3'h2) |-> s_rd_return)
      else $error("read return late");
   chk_act_then_rw: assert property (is_act |-> ##[1:16] (is_rd || is_wr)) else $error("activate unused");
   chk_sr_entry: assert property ($fell(mem_clock_enable) |-> cmd == `SDRPI_CMD_SELF_REFRESH)
      else $error("bad self refresh entry");
   chk_no_burst_stop: assert property (cmd != `SDRPI_CMD_BURST_STOP) else $error("burst stop seen");
   chk_clk_forward: assert property (@(negedge clk_sys) mem_clock_out) else $error("clock not forwarded");
endmodule // sdrpi_core_sva
bind sdrpi_core sdrpi_core_sva u_sva (.*);

// ---- verif/sdrpi_mem_model.sv ----
// Behavioural SDR SDRAM seen from the pins, CAS latency fixed by parameter
`timescale 1ns/1ps
`include "sdrpi_map.vh"
module sdrpi_mem_model #(
   parameter CL = 2
) (
   input  logic        clk,
   input  logic        cke,
   input  logic [2:0]  cmd,
   input  logic [1:0]  ba,
   input  logic [12:0] a,
   input  logic [3:0]  dqm,
   input  logic [31:0] dq_in,
   output logic [31:0] dq_out
);
   logic [31:0] mem [0:63];
   logic [31:0] last;
   logic [5:0]  radr;
   logic [2:0]  cnt;
   wire  [5:0]  idx = {ba, a[3:0]};
   initial begin
      for (int i = 0; i < 64; i++) mem[i] = 32'h0;
      cnt = 3'h0;
      last = 32'h0;
   end
   always @(posedge clk) begin
      if (cke && cmd == `SDRPI_CMD_WRITE)
         for (int i = 0; i < 4; i++) if (!dqm[i]) mem[idx][8*i+:8] <= dq_in[8*i+:8];
      if (cke && cmd == `SDRPI_CMD_READ) begin
         cnt <= CL;
         radr <= idx;
      end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
      if (cnt == 3'h1) last <= dq_out;
   end
   // Outside the data slot the bus shows the inverse, so a stale capture cannot pass
   assign dq_out = (cnt == 3'h1) ? mem[radr] : ~last;
endmodule // sdrpi_mem_model

// ---- verif/sdrpi_core_tb.sv ----
// Self-checking bench for the SDR SDRAM pin interface
`timescale 1ns/1ps
`include "sdrpi_map.vh"
module sdrpi_core_tb;
   logic        clk_sys = 0, resetn = 0, cfg_bus16 = 0, self_refresh_req = 0;
   logic        wr_valid = 0, rd_valid = 0, wr_ready, rd_ready, wr_done, rd_data_valid;
   logic        self_refresh_active, init_done, mem_clock_out, mem_clock_enable, chip_select_n;
   logic        row_strobe_n, column_strobe_n, write_strobe_n, mem_data_oe;
   logic [2:0]  cfg_cas_lat = 3'h2;
   logic [3:0]  cfg_trcd = 4'h2, cfg_trp = 4'h2, cfg_trfc = 4'h3, wr_byte_en = 4'h0, byte_lane_mask;
   logic [3:0]  wr_id = 4'h0, rd_id = 4'h0, wr_done_id, rd_data_id;
   logic [12:0] cfg_refresh_period = 13'h0040, mem_addr_bus;
   logic [23:0] wr_addr = 24'h0, rd_addr = 24'h0;
   logic [31:0] wr_data = 32'h0, rd_data, mem_data_out, mem_data_in;
   logic [1:0]  mem_bank_select;
   int          fail_count = 0, tests_run = 0, cyc = 0, ref_cnt = 0;
   wire  [2:0]  cmd = {row_strobe_n, column_strobe_n, write_strobe_n};
   localparam [23:0] A1 = {13'h0123, 2'h1, 9'h003};
   localparam [23:0] A2 = {13'h0123, 2'h1, 9'h005};
   localparam [23:0] A3 = {13'h0042, 2'h2, 9'h007};
   sdrpi_core #(.INIT_WAIT_CYC(10)) uut (.*);
   sdrpi_mem_model #(.CL(2)) u_mem (.clk(mem_clock_out), .cke(mem_clock_enable), .cmd(cmd),
      .ba(mem_bank_select), .a(mem_addr_bus), .dqm(byte_lane_mask), .dq_in(mem_data_out), .dq_out(mem_data_in));
   always #2.5 clk_sys = ~clk_sys;
   always @(negedge clk_sys) if (resetn && mem_clock_enable && cmd == `SDRPI_CMD_AUTO_REFRESH) ref_cnt++;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end
   // ************************
   // Shared tasks
   // ************************
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic do_wr(input logic [23:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      logic [1:0]  ab;
      logic [12:0] ar;
      n = 0;
      wr_addr = a;
      wr_data = d;
      wr_byte_en = be;
      wr_id = wr_id + 4'h1;
      wr_valid = 1'b1;
      while (!wr_ready) @(negedge clk_sys);
      @(negedge clk_sys);
      wr_valid = 1'b0;
      while (wr_done !== 1'b1 && n < 300) begin
         if (cmd == `SDRPI_CMD_ACTIVATE) begin
            ab = mem_bank_select;
            ar = mem_addr_bus;
         end
         @(negedge clk_sys);
         n++;
      end
      chk(wr_done_id === wr_id && cmd === `SDRPI_CMD_WRITE, "write done");
      chk(ab === a[10:9] && ar === a[23:11] && mem_bank_select === a[10:9], "bank or row");
      chk(mem_addr_bus[8:0] === a[8:0] && mem_addr_bus[10] === 1'b0, "write column");
      chk(byte_lane_mask === (~be | {cfg_bus16, cfg_bus16, 2'b00}), "byte mask");
   endtask
   task automatic do_rd(input logic [23:0] a, input logic [31:0] exp);
      int n;
      n = 0;
      rd_addr = a;
      rd_id = rd_id + 4'h1;
      rd_valid = 1'b1;
      while (!rd_ready) @(negedge clk_sys);
      @(negedge clk_sys);
      rd_valid = 1'b0;
      while (rd_data_valid !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      chk(rd_data === exp && rd_data_id === rd_id, "read data");
   endtask
   task automatic t_self_refresh();
      int n;
      n = 0;
      self_refresh_req = 1'b1;
      while (self_refresh_active !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      repeat (20) @(negedge clk_sys);
      chk(mem_clock_enable === 1'b0 && chip_select_n === 1'b0, "self refresh hold");
      self_refresh_req = 1'b0;
      while (self_refresh_active !== 1'b0 && n < 600) begin
         @(negedge clk_sys);
         n++;
      end
      @(negedge clk_sys);
      chk(mem_clock_enable === 1'b1, "self refresh exit");
   endtask
   task automatic report_and_stop();
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge clk_sys);
      resetn = 1'b1;
      while (init_done !== 1'b1) @(negedge clk_sys);
      chk(ref_cnt == 2 && cmd === `SDRPI_CMD_MODE_LOAD, "init refreshes");
      chk(mem_addr_bus === {6'h00, cfg_cas_lat, 4'h0}, "mode load word");
      @(negedge clk_sys);
      chk(cmd === `SDRPI_CMD_IDLE, "idle after mode load");
      do_wr(A1, 32'h1234_5678, 4'hf);
      do_rd(A1, 32'h1234_5678);
      do_wr(A1, 32'haabb_ccdd, 4'h5);
      do_rd(A1, 32'h12bb_56dd);
      fork
         do_wr(A2, 32'h0f0f_a5a5, 4'hf);
         do_rd(A1, 32'h12bb_56dd);
      join
      do_rd(A2, 32'h0f0f_a5a5);
      cfg_bus16 = 1'b1;
      do_wr(A3, 32'hdead_beef, 4'hf);
      do_rd(A3, 32'h0000_beef);
      cfg_bus16 = 1'b0;
      t_self_refresh();
      do_rd(A2, 32'h0f0f_a5a5);
      // Counter moves on falling edges, so clear and read it on rising ones
      repeat (20) @(posedge clk_sys);
      ref_cnt = 0;
      // Three refresh intervals of 65 cycles each
      repeat (195) @(posedge clk_sys);
      chk(ref_cnt == 3, "periodic refresh");
      report_and_stop();
   end
endmodule // sdrpi_core_tb
